//--- design/fractional_vector_multiply_unit.sv
`timescale 1ns/1ps
`include "fvmu_consts.svh"

// How it works
// - low-word write with selector 1..3 and extension off raises disabled exception
// - left-lane q31 multiply uses bits 31..16 of both sources
// - right-lane q31 multiply uses bits 15..0 of both sources
// - q31 result is signed half product shifted left once, full word
// - both operands 0x8000 give 0x7fffffff instead
// - q31 saturation sets overflow bit 21 of the control register
// - multiplies leave accumulators one to three untouched
// - byte multiply pairs bytes 31..24 and 23..16 with the two half-words
// - a lane product above sixteen bits becomes 0xffff
// - either byte lane saturating sets overflow bit 21
// - upper byte lane lands in bits 31..16, lower in 15..0
// - multiplies raise no data-dependent exception
// - low word is accumulator bits 31..0, selector zero is the base pair
module fractional_vector_multiply_unit import fvmu_pkg::*; (
  input wire logic clk,
  input wire logic resetn,
  input wire logic op_valid,
  input wire logic [31:0] instruction,
  input wire logic [31:0] first_source_register,
  input wire logic [31:0] second_source_register,
  input wire logic extension_enable_bit,
  input wire logic control_write,
  input wire logic [31:0] control_write_data,
  input wire logic [1:0] acc_read_select,
  output logic result_valid,
  output logic [31:0] result_data,
  output logic [4:0] result_dest,
  output logic dsp_disabled_exception,
  output logic [31:0] extension_control_register,
  output logic [63:0] acc_read_data
);

  state_type state;
  state_type next_state;
  op_kind_type op_kind;
  logic [1:0] accumulator_selector;
  logic [31:0] q31_product;
  logic q31_saturated;
  logic [31:0] byte_product;
  logic byte_saturated;

  function automatic op_kind_type decode(input logic [31:0] instr);
    logic [5:0] major;
    logic [5:0] func;
    logic [4:0] sub;
    major = instr[`MAJOR_MSB:`MAJOR_LSB];
    func = instr[`FUNC_MSB:`FUNC_LSB];
    sub = instr[`SUB_MSB:`SUB_LSB];
    decode = OP_NONE;
    if (major == `MAJOR_BASE && func == `FUNC_MOVE_LO) begin
      decode = OP_MOVE_LO;
    end else if (major == `MAJOR_BASE && func == `FUNC_MOVE_HI) begin
      decode = OP_MOVE_HI;
    end else if (major == `MAJOR_EXT && func == `FUNC_EXT_MUL) begin
      case (sub)
        `SUB_Q31_LEFT: decode = OP_Q31_LEFT;
        `SUB_Q31_RIGHT: decode = OP_Q31_RIGHT;
        `SUB_UBYTE_LEFT: decode = OP_UBYTE_LEFT;
        default: decode = OP_NONE;
      endcase
    end
  endfunction

  lane_multiplier multiplier (
    .first_source_register(first_source_register),
    .second_source_register(second_source_register),
    .right_lane(op_kind == OP_Q31_RIGHT),
    .q31_product(q31_product),
    .q31_saturated(q31_saturated),
    .byte_product(byte_product),
    .byte_saturated(byte_saturated)
  );

  // decoded outside the state process so the multiplier path forms no loop through it
  assign op_kind = decode(instruction);
  assign accumulator_selector = instruction[`SEL_MSB:`SEL_LSB];

  always_comb begin
    next_state = state;
    next_state.result_valid = 1'b0;
    next_state.dsp_disabled_exception = 1'b0;
    next_state.result_dest = instruction[`DEST_MSB:`DEST_LSB];
    next_state.acc_read_data = state.acc[acc_read_select];
    // software write first so a same-cycle saturation still wins
    if (control_write) begin
      next_state.control = control_write_data;
    end
    if (op_valid) begin
      case (op_kind)
        OP_MOVE_LO: begin
          if (accumulator_selector != 2'b00 && !extension_enable_bit) begin
            next_state.dsp_disabled_exception = 1'b1;
          end else begin
            next_state.acc[accumulator_selector][31:0] = first_source_register;
          end
        end
        OP_MOVE_HI: begin
          if (accumulator_selector != 2'b00 && !extension_enable_bit) begin
            next_state.dsp_disabled_exception = 1'b1;
          end else begin
            // low half kept as is; pairing order is software's concern
            next_state.acc[accumulator_selector][63:32] = first_source_register;
          end
        end
        OP_Q31_LEFT, OP_Q31_RIGHT: begin
          // only the enable can refuse a multiply, never the data
          if (!extension_enable_bit) begin
            next_state.dsp_disabled_exception = 1'b1;
          end else begin
            next_state.result_valid = 1'b1;
            next_state.result_data = q31_product;
            if (q31_saturated) begin
              next_state.control[`OVERFLOW_BIT] = 1'b1;
            end
          end
        end
        OP_UBYTE_LEFT: begin
          if (!extension_enable_bit) begin
            next_state.dsp_disabled_exception = 1'b1;
          end else begin
            next_state.result_valid = 1'b1;
            next_state.result_data = byte_product;
            if (byte_saturated) begin
              next_state.control[`OVERFLOW_BIT] = 1'b1;
            end
          end
        end
        default: begin
          next_state.result_valid = 1'b0;
        end
      endcase
    end
  end

  // accumulator zero is left intact by multiplies, a legal choice
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state.acc <= {4{`ACC_RESET}};
      state.control <= `CONTROL_RESET;
      state.result_valid <= 1'b0;
      state.result_data <= `WORD_RESET;
      state.result_dest <= 5'h00;
      state.dsp_disabled_exception <= 1'b0;
      state.acc_read_data <= `ACC_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign result_valid = state.result_valid;
  assign result_data = state.result_data;
  assign result_dest = state.result_dest;
  assign dsp_disabled_exception = state.dsp_disabled_exception;
  assign extension_control_register = state.control;
  assign acc_read_data = state.acc_read_data;

endmodule

//--- design/fvmu_consts.svh
`ifndef FVMU_CONSTS_SVH
`define FVMU_CONSTS_SVH

// instruction word fields
`define MAJOR_MSB 31
`define MAJOR_LSB 26
`define FUNC_MSB 5
`define FUNC_LSB 0
`define SUB_MSB 10
`define SUB_LSB 6
`define DEST_MSB 15
`define DEST_LSB 11
`define SEL_MSB 12
`define SEL_LSB 11

// opcode values
`define MAJOR_BASE 6'h00
`define MAJOR_EXT 6'h1f
`define FUNC_MOVE_LO 6'h13
`define FUNC_MOVE_HI 6'h11
`define FUNC_EXT_MUL 6'h10
`define SUB_Q31_LEFT 5'h1c
`define SUB_Q31_RIGHT 5'h1d
`define SUB_UBYTE_LEFT 5'h06

// saturation values and flag position
`define Q15_MIN 16'h8000
`define Q31_MAX 32'h7fffffff
`define U16_MAX 16'hffff
`define OVERFLOW_BIT 21

// reset values
`define CONTROL_RESET 32'h0000_0000
`define ACC_RESET 64'h0000_0000_0000_0000
`define WORD_RESET 32'h0000_0000

`endif

//--- design/fvmu_pkg.sv
package fvmu_pkg;

  typedef enum logic [5:0] {
    OP_NONE = 6'b000001,
    OP_MOVE_LO = 6'b000010,
    OP_MOVE_HI = 6'b000100,
    OP_Q31_LEFT = 6'b001000,
    OP_Q31_RIGHT = 6'b010000,
    OP_UBYTE_LEFT = 6'b100000
  } op_kind_type;

  typedef struct packed {
    logic [3:0][63:0] acc;
    logic [31:0] control;
    logic result_valid;
    logic [31:0] result_data;
    logic [4:0] result_dest;
    logic dsp_disabled_exception;
    logic [63:0] acc_read_data;
  } state_type;

endpackage

//--- design/lane_multiplier.sv
`timescale 1ns/1ps
`include "fvmu_consts.svh"

module lane_multiplier (
  input wire logic [31:0] first_source_register,
  input wire logic [31:0] second_source_register,
  input wire logic right_lane,
  output logic [31:0] q31_product,
  output logic q31_saturated,
  output logic [31:0] byte_product,
  output logic byte_saturated
);

  // returns {saturated, lane value}
  function automatic logic [16:0] sat_lane(input logic [7:0] x, input logic [15:0] y);
    logic [23:0] p;
    p = {16'h0000, x} * {8'h00, y};
    if (|p[23:16]) begin
      sat_lane = {1'b1, `U16_MAX};
    end else begin
      sat_lane = {1'b0, p[15:0]};
    end
  endfunction

  logic [15:0] a;
  logic [15:0] b;
  logic signed [31:0] prod;
  logic [16:0] upper_lane;
  logic [16:0] lower_lane;

  always_comb begin
    a = right_lane ? first_source_register[15:0] : first_source_register[31:16];
    b = right_lane ? second_source_register[15:0] : second_source_register[31:16];
    prod = $signed(a) * $signed(b);
    q31_saturated = (a == `Q15_MIN) && (b == `Q15_MIN);
    // only -1 * -1 can overflow the doubled product
    q31_product = q31_saturated ? `Q31_MAX : {prod[30:0], 1'b0};
    upper_lane = sat_lane(first_source_register[31:24], second_source_register[31:16]);
    lower_lane = sat_lane(first_source_register[23:16], second_source_register[15:0]);
    byte_product = {upper_lane[15:0], lower_lane[15:0]};
    byte_saturated = upper_lane[16] | lower_lane[16];
  end

endmodule

//--- dv/fvmu_chk.sv
`timescale 1ns/1ps
`include "fvmu_consts.svh"
module fvmu_chk (
  input wire logic clk,
  input wire logic resetn,
  input wire logic op_valid,
  input wire logic [31:0] instruction,
  input wire logic [31:0] first_source_register,
  input wire logic [31:0] second_source_register,
  input wire logic extension_enable_bit,
  input wire logic control_write,
  input wire logic result_valid,
  input wire logic [31:0] result_data,
  input wire logic dsp_disabled_exception,
  input wire logic [31:0] extension_control_register
);
  logic [31:0] a, b;
  logic [4:0] sub;
  logic go, qs, bs, flag;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  function automatic logic [31:0] q31(input logic [15:0] x, y);
    logic signed [31:0] p;
    p = $signed(x) * $signed(y);
    return (x == `Q15_MIN && y == `Q15_MIN) ? `Q31_MAX : p << 1;
  endfunction
  function automatic logic [15:0] u16(input logic [7:0] x, input logic [15:0] y);
    logic [23:0] p;
    p = x * y;
    return p > 24'hffff ? `U16_MAX : p[15:0];
  endfunction
  assign a = first_source_register;
  assign b = second_source_register;
  assign sub = instruction[10:6];
  assign flag = extension_control_register[`OVERFLOW_BIT];
  assign go = op_valid && extension_enable_bit && instruction[31:26] == `MAJOR_EXT &&
    instruction[5:0] == `FUNC_EXT_MUL;
  // an even product never equals the clamp value, so this detects saturation
  assign qs = go && (sub == `SUB_Q31_LEFT && q31(a[31:16], b[31:16]) == `Q31_MAX ||
    sub == `SUB_Q31_RIGHT && q31(a[15:0], b[15:0]) == `Q31_MAX);
  assign bs = go && sub == `SUB_UBYTE_LEFT && (a[31:24] * b[31:16] > 24'hffff || a[23:16] * b[15:0] > 24'hffff);
  a_q31_left: assert property (go && sub == `SUB_Q31_LEFT |=> result_valid &&
    result_data == q31($past(a[31:16]), $past(b[31:16]))) else $error("left lane result wrong");
  a_q31_right: assert property (go && sub == `SUB_Q31_RIGHT |=> result_valid &&
    result_data == q31($past(a[15:0]), $past(b[15:0]))) else $error("right lane result wrong");
  a_byte_pack: assert property (go && sub == `SUB_UBYTE_LEFT |=> result_valid &&
    result_data == {u16($past(a[31:24]), $past(b[31:16])), u16($past(a[23:16]), $past(b[15:0]))})
    else $error("byte lanes wrong");
  a_q31_flag: assert property (qs |=> flag) else $error("q31 flag not set");
  a_byte_flag: assert property (bs |=> flag) else $error("byte flag not set");
  a_flag_sticky: assert property (flag && !control_write |=> flag) else $error("flag cleared");
  a_no_data_exc: assert property (go |=> !dsp_disabled_exception) else $error("multiply raised");
  a_move_refused: assert property (op_valid && !extension_enable_bit && instruction[12:11] != 2'h0 &&
    instruction[31:26] == `MAJOR_BASE && instruction[5:0] == `FUNC_MOVE_LO |=> dsp_disabled_exception)
    else $error("move not refused");
  cover property (qs);
  cover property (bs);
  cover property (dsp_disabled_exception);
endmodule

//--- dv/host_model.sv
`timescale 1ns/1ps
`include "fvmu_consts.svh"
module host_model (
  input wire logic mul,
  input wire logic hi,
  input wire logic [4:0] sub,
  input wire logic [1:0] sel,
  output logic [31:0] instruction
);
  // half moves never follow an unread base result
  // accumulator zero is never relied on across a multiply
  assign instruction = mul ? {`MAJOR_EXT, 10'h000, sub, sub, `FUNC_EXT_MUL} :
    {`MAJOR_BASE, 13'h0000, sel, 5'h00, hi ? `FUNC_MOVE_HI : `FUNC_MOVE_LO};
endmodule

//--- dv/tb.sv
`timescale 1ns/1ps
`include "fvmu_consts.svh"
module tb;
  logic clk = 0, resetn = 0, op_valid = 0, extension_enable_bit = 1, control_write = 0, mul = 0, hi = 0;
  logic [31:0] first_source_register = 0, second_source_register = 0, control_write_data = 0;
  logic [31:0] instruction, result_data, extension_control_register;
  logic [1:0] acc_read_select = 0, sel = 0;
  logic [4:0] sub = 0, result_dest;
  logic result_valid, dsp_disabled_exception;
  logic [63:0] acc_read_data;
  int n_fail = 0, n_tests = 0, cyc = 0;
  typedef struct {logic [4:0] s; logic [31:0] a, b, e;} row_type;
  row_type rows[8] = '{'{`SUB_Q31_LEFT, 32'h4000_1234, 32'h2000_ffff, 32'h1000_0000},
    '{`SUB_Q31_LEFT, 32'h8000_0001, 32'h8000_0002, `Q31_MAX},
    '{`SUB_Q31_LEFT, 32'h8000_0000, 32'h7fff_0000, 32'h8001_0000},
    '{`SUB_Q31_RIGHT, 32'h7fff_fffe, 32'h1234_0003, 32'hffff_fff4},
    '{`SUB_Q31_RIGHT, 32'h0001_8000, 32'h0002_8000, `Q31_MAX},
    '{`SUB_UBYTE_LEFT, 32'h0203_ffff, 32'h1000_0100, 32'h2000_0300},
    '{`SUB_UBYTE_LEFT, 32'h1001_0000, 32'h1000_ffff, 32'hffff_ffff},
    '{`SUB_UBYTE_LEFT, 32'h0102_0000, 32'h0001_8000, 32'h0001_ffff}};
  always #10 clk = ~clk;
  host_model host (.mul, .hi, .sub, .sel, .instruction);
  fractional_vector_multiply_unit dut (.clk, .resetn, .op_valid, .instruction,
    .first_source_register, .second_source_register, .extension_enable_bit,
    .control_write, .control_write_data, .acc_read_select,
    .result_valid, .result_data, .result_dest, .dsp_disabled_exception,
    .extension_control_register, .acc_read_data);
  task summarize;
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input string nm, input logic [63:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task run(input logic m, input logic [4:0] s, input logic [1:0] l, input logic [31:0] x, y);
    @(posedge clk);
    op_valid <= 1;
    mul <= m;
    sub <= s;
    sel <= l;
    first_source_register <= x;
    second_source_register <= y;
    @(posedge clk);
    op_valid <= 0;
    @(negedge clk);
  endtask
  task rd(input logic [1:0] l, input logic [63:0] e);
    @(posedge clk);
    acc_read_select <= l;
    // the edge that samples the select also registers the answer
    @(posedge clk);
    @(negedge clk);
    chk("acc", acc_read_data, e);
  endtask
  task wr(input logic [31:0] d);
    @(posedge clk);
    control_write <= 1;
    control_write_data <= d;
    @(posedge clk);
    control_write <= 0;
  endtask
  task mrow(input int k, input logic f);
    run(1, rows[k].s, 0, rows[k].a, rows[k].b);
    chk("flag", extension_control_register[`OVERFLOW_BIT], f);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc > 1000) begin
      n_fail++;
      summarize;
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1;
    @(negedge clk);
    chk("ctl", extension_control_register, 0);
    run(0, 0, 1, 32'h1234_5678, 0);
    rd(1, 64'h1234_5678);
    @(posedge clk);
    hi <= 1;
    run(0, 0, 1, 32'h5a5a_0001, 0);
    rd(1, 64'h5a5a_0001_1234_5678);
    foreach (rows[i]) begin
      run(1, rows[i].s, 0, rows[i].a, rows[i].b);
      chk("res", result_data, rows[i].e);
      chk("dst", result_dest, rows[i].s);
      chk("vld", result_valid, 1);
    end
    rd(1, 64'h5a5a_0001_1234_5678);
    wr(0);
    mrow(0, 0);
    mrow(7, 1);
    mrow(5, 1);
    wr(0);
    mrow(4, 1);
    @(posedge clk);
    extension_enable_bit <= 0;
    hi <= 0;
    run(0, 0, 2, 32'h5, 0);
    chk("exc", dsp_disabled_exception, 1);
    rd(2, 0);
    run(0, 0, 0, 32'h9, 0);
    chk("exc", dsp_disabled_exception, 0);
    rd(0, 64'h9);
    // mid-run reset must clear the sticky flag, results and accumulators
    @(posedge clk);
    resetn <= 0;
    @(negedge clk);
    chk("rst", {extension_control_register, result_data}, 0);
    @(posedge clk);
    resetn <= 1;
    run(1, `SUB_Q31_LEFT, 0, 32'h8000_0000, 32'h8000_0000);
    chk("off", {dsp_disabled_exception, result_valid}, 2'b10);
    chk("flag", extension_control_register, 0);
    rd(1, 0);
    summarize;
  end
endmodule
bind fractional_vector_multiply_unit fvmu_chk chk (.clk, .resetn, .op_valid, .instruction,
  .first_source_register, .second_source_register, .extension_enable_bit, .control_write,
  .result_valid, .result_data, .dsp_disabled_exception, .extension_control_register);
